// ### pkg/liu_regs_consts.vh
// register offsets, field positions and reset values of the host register bank
`ifndef LIU_REGS_CONSTS_VH
`define LIU_REGS_CONSTS_VH
`define ADR_IDENTITY      5'h00
`define ADR_ANALOG_LOOP   5'h01
`define ADR_REMOTE_LOOP   5'h02
`define ADR_ALL_ONES_TX   5'h03
`define ADR_SIG_ABSENT    5'h04
`define ADR_DRV_FAULT     5'h05
`define ADR_SA_IRQ_EN     5'h06
`define ADR_DF_IRQ_EN     5'h07
`define ADR_SA_IRQ_FLG    5'h08
`define ADR_DF_IRQ_FLG    5'h09
`define ADR_SOFT_RESET    5'h0A
`define ADR_MON_SEL       5'h0B
`define ADR_DIG_LOOP      5'h0C
`define ADR_ALARM_MODE    5'h0D
`define ADR_AUTO_ONES     5'h0E
`define ADR_GLOBAL_CTL    5'h0F
`define ADR_LEN_CHAN      5'h10
`define ADR_LEN_DATA      5'h11
`define ADR_OUT_DIS       5'h12
`define ADR_AIS_STAT      5'h13
`define ADR_AIS_IRQ_EN    5'h14
`define ADR_AIS_IRQ_FLG   5'h15
`define ADR_WAVE_BCAST    5'h16
`define ADR_WAVE_PH_ADR   5'h17
`define ADR_WAVE_PH_DAT   5'h18
`define ADR_WAVE_EN       5'h19
`define ADR_WAVE_OV_EN    5'h1A
`define ADR_WAVE_OV_FLG   5'h1B
`define ADR_CLK_REC_EN    5'h1E
`define ADR_WIDTH         5
`define ID_PART_MSB       7
`define ID_PART_LSB       4
`define ID_REV_MSB        3
`define ID_REV_LSB        0
`define MON_SEL_MASK      8'h0F
`define LEN_CHAN_MASK     8'h07
`define LEN_DATA_MASK     8'h1F
`define WAVE_DAT_MASK     8'h7F
`define REG_RESET         8'h00
`endif

// ### design/line_interface_host_register_bank.v
// host-mode register bank of an eight channel line interface
`timescale 1ns/1ps
// overview: the host port front end hands this bank one strobe per
// access, already cut down to a single clock cycle.  a read is answered
// one cycle later on reg_rdata_o together with reg_rvalid_o; a write
// lands on the edge that takes it, and the channel controls follow one
// cycle after that, since every top-level output comes from a flop.
//
// only the low five address bits are decoded, so the upper three are
// don't-care inside the bank even though the host keeps them at zero.
// addresses without a register, and reserved bits, read back as zero.
//
// status registers are copies of the line-side levels, one cycle late.
// each change flag register is sticky: any edge of its status bit sets
// it and a host read of that flag register clears it.  an event in the
// very cycle of the read wins over the clear, so none is ever lost in
// the gap between reading the flags and clearing them.
//
// a write of any value to the reset register returns every register,
// status copy and flag to zero on the edge that takes the write; the
// channel outputs follow one cycle later, like after any other write.
//
// outside host mode every strobe is dropped before decode: no access
// changes a register and no read answer appears, while the stored settings keep
// driving the channels.
//
// register groups: per-channel controls (loopbacks, all-ones, output
// disable, waveform and clock recovery enables) feed the channel outputs;
// status copies and change flags come from the line side; the line
// length pair is a selector and an eight-slot store behind one address;
// the identity register is a constant built from two parameters.
//
// limitation: no interrupt pin is driven here; the enable and flag
// registers are read back by the host; beyond that only the overflow enables act, gating their flags.
//
`include "liu_regs_consts.vh"

module line_interface_host_register_bank #(
  parameter [3:0] PART_NIBBLE = 4'h5,  // identity nibble, value arbitrary
  parameter [3:0] REVISION    = 4'h1   // revision field, value arbitrary
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rstn_i,
  // mode strap: high while in host mode
  // low drops every read and write strobe
  input  wire       host_mode_i,
  // register access from host port front end
  // one-cycle strobes, address and data valid with them
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  // per-channel status from the line side
  // plain levels, sampled on every clock edge
  input  wire [7:0] signal_absent_i,
  input  wire [7:0] driver_fault_i,
  input  wire [7:0] alarm_ind_i,
  input  wire [7:0] wave_overflow_i,
  // control to the channels
  // each a registered copy of its control register; soft_reset_o is a registered copy of the reset register write strobe
  output reg  [7:0] analog_loop_o,
  output reg  [7:0] remote_loop_o,
  output reg  [7:0] all_ones_tx_o,
  output reg  [7:0] digital_loop_o,
  output reg  [7:0] output_disable_o,
  output reg  [7:0] wave_enable_o,
  output reg  [7:0] clock_recovery_o,
  output reg  [3:0] monitor_select_o,
  output reg        soft_reset_o
);

  // every register is eight bits wide; masked ones keep their reserved
  // bits at zero so the read multiplexer needs no masks of its own
  // read/write control registers
  reg [7:0] analog_loop_q;    // per-channel analog loopback
  reg [7:0] remote_loop_q;    // per-channel remote loopback
  reg [7:0] all_ones_q;       // per-channel all-ones transmit
  reg [7:0] sa_en_q;          // signal-absent irq enables
  reg [7:0] df_en_q;          // driver-fault irq enables
  reg [7:0] mon_sel_q;        // monitor channel select
  reg [7:0] dig_loop_q;       // digital loopback
  reg [7:0] alarm_mode_q;     // alarm mode enable
  reg [7:0] auto_ones_q;      // automatic all-ones
  reg [7:0] global_q;         // global control
  reg [7:0] len_chan_q;       // line length channel selector
  reg [7:0] out_dis_q;        // output disable
  reg [7:0] ais_en_q;         // alarm indication irq enables
  reg [7:0] wave_bcast_q;     // waveform broadcast
  reg [7:0] wave_ph_adr_q;    // waveform phase address
  reg [7:0] wave_ph_dat_q;    // waveform phase sample
  reg [7:0] wave_en_q;        // waveform generator enables
  reg [7:0] wave_ov_en_q;     // waveform overflow irq enables
  reg [7:0] clk_rec_q;        // clock recovery enables
  // one line length setting per channel; the selector picks which one
  reg [7:0] len_data_q [0:7];
  // status samples and change flags
  // the status copies double as the previous value for edge detection
  reg [7:0] sa_stat_q;        // signal absent status
  reg [7:0] df_stat_q;        // driver fault status
  reg [7:0] ais_stat_q;       // alarm indication status
  reg [7:0] sa_flg_q;         // signal-absent change flags
  reg [7:0] df_flg_q;         // driver-fault change flags
  reg [7:0] ais_flg_q;        // alarm indication change flags
  reg [7:0] wave_ov_flg_q;    // waveform overflow flags

  // decoded address: upper three bits are ignored
  wire [4:0] adr = reg_addr_i[4:0];
  // accesses only count in host mode
  // gating the strobes here, before any decode, means that no write
  // branch and no read side effect needs its own mode check
  wire       wr  = reg_wr_i & host_mode_i;
  wire       rd  = reg_rd_i & host_mode_i;
  // a write to the reset register clears everything
  // the data byte is ignored: any value written counts as a reset
  wire       sw_rst = wr & (adr == `ADR_SOFT_RESET);
  // hardware and software reset share one synchronous clear, so the
  // two can never leave the registers in different states
  wire       clr    = ~rstn_i | sw_rst;

  // write strobe for one address
  // one compare per register keeps every write branch the same shape
  function wr_hit;
    input [4:0] a;
    input [4:0] target;
    input       w;
    begin
      wr_hit = w & (a == target);
    end
  endfunction

  // read strobe for one flag register; reading clears its flags
  // these are the only reads with a side effect; all other reads are
  // free of state changes and may be repeated at will
  wire rd_sa_flg  = rd & (adr == `ADR_SA_IRQ_FLG);
  wire rd_df_flg  = rd & (adr == `ADR_DF_IRQ_FLG);
  wire rd_ais_flg = rd & (adr == `ADR_AIS_IRQ_FLG);
  wire rd_wov_flg = rd & (adr == `ADR_WAVE_OV_FLG);

  // control register writes; read-only addresses have no write branch
  always @(posedge clk_sys_i) begin
    if (clr) begin
      analog_loop_q <= `REG_RESET;
      remote_loop_q <= `REG_RESET;
      all_ones_q    <= `REG_RESET;
      sa_en_q       <= `REG_RESET;
      df_en_q       <= `REG_RESET;
      mon_sel_q     <= `REG_RESET;
      dig_loop_q    <= `REG_RESET;
      alarm_mode_q  <= `REG_RESET;
      auto_ones_q   <= `REG_RESET;
      global_q      <= `REG_RESET;
      len_chan_q    <= `REG_RESET;
      out_dis_q     <= `REG_RESET;
      ais_en_q      <= `REG_RESET;
      wave_bcast_q  <= `REG_RESET;
      wave_ph_adr_q <= `REG_RESET;
      wave_ph_dat_q <= `REG_RESET;
      wave_en_q     <= `REG_RESET;
      wave_ov_en_q  <= `REG_RESET;
      clk_rec_q     <= `REG_RESET;
      // every line length slot is cleared, not only the selected one
      len_data_q[0] <= `REG_RESET;
      len_data_q[1] <= `REG_RESET;
      len_data_q[2] <= `REG_RESET;
      len_data_q[3] <= `REG_RESET;
      len_data_q[4] <= `REG_RESET;
      len_data_q[5] <= `REG_RESET;
      len_data_q[6] <= `REG_RESET;
      len_data_q[7] <= `REG_RESET;
    end else begin
      // loopback and all-ones controls, one bit per channel
      if (wr_hit(adr, `ADR_ANALOG_LOOP, wr)) begin
        analog_loop_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_REMOTE_LOOP, wr)) begin
        remote_loop_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_ALL_ONES_TX, wr)) begin
        all_ones_q <= reg_wdata_i;
      end
      // interrupt enables are kept for the host only; no pin is driven
      // from them inside this bank
      if (wr_hit(adr, `ADR_SA_IRQ_EN, wr)) begin
        sa_en_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_DF_IRQ_EN, wr)) begin
        df_en_q <= reg_wdata_i;
      end
      // reserved upper bits are dropped so that they always read zero
      if (wr_hit(adr, `ADR_MON_SEL, wr)) begin
        mon_sel_q <= reg_wdata_i & `MON_SEL_MASK;
      end
      // further per-channel and global settings, stored as written
      if (wr_hit(adr, `ADR_DIG_LOOP, wr)) begin
        dig_loop_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_ALARM_MODE, wr)) begin
        alarm_mode_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_AUTO_ONES, wr)) begin
        auto_ones_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_GLOBAL_CTL, wr)) begin
        global_q <= reg_wdata_i;
      end
      // the selector must be written before the data register below;
      // a data write always lands in the slot chosen at that moment
      if (wr_hit(adr, `ADR_LEN_CHAN, wr)) begin
        len_chan_q <= reg_wdata_i & `LEN_CHAN_MASK;
      end
      // data lands in the slot of the selected channel
      if (wr_hit(adr, `ADR_LEN_DATA, wr)) begin
        len_data_q[len_chan_q[2:0]] <= reg_wdata_i & `LEN_DATA_MASK;
      end
      // output disable and alarm indication enables
      if (wr_hit(adr, `ADR_OUT_DIS, wr)) begin
        out_dis_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_AIS_IRQ_EN, wr)) begin
        ais_en_q <= reg_wdata_i;
      end
      // waveform generator settings; only the sample keeps a mask,
      // as its top bit is reserved
      if (wr_hit(adr, `ADR_WAVE_BCAST, wr)) begin
        wave_bcast_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_WAVE_PH_ADR, wr)) begin
        wave_ph_adr_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_WAVE_PH_DAT, wr)) begin
        wave_ph_dat_q <= reg_wdata_i & `WAVE_DAT_MASK;
      end
      if (wr_hit(adr, `ADR_WAVE_EN, wr)) begin
        wave_en_q <= reg_wdata_i;
      end
      if (wr_hit(adr, `ADR_WAVE_OV_EN, wr)) begin
        wave_ov_en_q <= reg_wdata_i;
      end
      // clock recovery enables, one bit per channel
      if (wr_hit(adr, `ADR_CLK_REC_EN, wr)) begin
        clk_rec_q <= reg_wdata_i;
      end
    end
  end

  // status sampling and sticky change flags; a new change beats the read clear
  // the status copies give the flags a clean one-cycle history of each
  // input; a change is the xor of that copy and the present input
  always @(posedge clk_sys_i) begin
    if (clr) begin
      sa_stat_q     <= `REG_RESET;
      df_stat_q     <= `REG_RESET;
      ais_stat_q    <= `REG_RESET;
      sa_flg_q      <= `REG_RESET;
      df_flg_q      <= `REG_RESET;
      ais_flg_q     <= `REG_RESET;
      wave_ov_flg_q <= `REG_RESET;
    end else begin
      sa_stat_q  <= signal_absent_i;
      df_stat_q  <= driver_fault_i;
      ais_stat_q <= alarm_ind_i;
      // flags record any edge of the sampled status
      // the xor is one for exactly one cycle per edge, and the or keeps
      // the flag set until its register is read
      sa_flg_q  <= (rd_sa_flg ? 8'h00 : sa_flg_q) | (sa_stat_q ^ signal_absent_i);
      df_flg_q  <= (rd_df_flg ? 8'h00 : df_flg_q) | (df_stat_q ^ driver_fault_i);
      ais_flg_q <= (rd_ais_flg ? 8'h00 : ais_flg_q) | (ais_stat_q ^ alarm_ind_i);
      // overflow flags only latch while enabled
      // a disabled channel never latches, so enabling it later does not
      // bring up an overflow that happened while it was off
      wave_ov_flg_q <= (rd_wov_flg ? 8'h00 : wave_ov_flg_q)
                       | (wave_overflow_i & wave_ov_en_q);
    end
  end

  // read multiplexer; unmapped and reserved addresses read zero
  // built from the flops only: a write lands on the edge, so a read in
  // the next cycle already sees the new value
  reg [7:0] rdata_d;
  always @* begin
    rdata_d = 8'h00;
    case (adr)
      `ADR_IDENTITY:    rdata_d = {PART_NIBBLE, REVISION};
      `ADR_ANALOG_LOOP: rdata_d = analog_loop_q;
      `ADR_REMOTE_LOOP: rdata_d = remote_loop_q;
      `ADR_ALL_ONES_TX: rdata_d = all_ones_q;
      `ADR_SIG_ABSENT:  rdata_d = sa_stat_q;
      `ADR_DRV_FAULT:   rdata_d = df_stat_q;
      `ADR_SA_IRQ_EN:   rdata_d = sa_en_q;
      `ADR_DF_IRQ_EN:   rdata_d = df_en_q;
      `ADR_SA_IRQ_FLG:  rdata_d = sa_flg_q;
      `ADR_DF_IRQ_FLG:  rdata_d = df_flg_q;
      // the reset register stores nothing and reads as zero
      `ADR_SOFT_RESET:  rdata_d = 8'h00;
      `ADR_MON_SEL:     rdata_d = mon_sel_q;
      `ADR_DIG_LOOP:    rdata_d = dig_loop_q;
      `ADR_ALARM_MODE:  rdata_d = alarm_mode_q;
      `ADR_AUTO_ONES:   rdata_d = auto_ones_q;
      `ADR_GLOBAL_CTL:  rdata_d = global_q;
      `ADR_LEN_CHAN:    rdata_d = len_chan_q;
      // the data register shows the slot of the selected channel
      `ADR_LEN_DATA:    rdata_d = len_data_q[len_chan_q[2:0]];
      `ADR_OUT_DIS:     rdata_d = out_dis_q;
      `ADR_AIS_STAT:    rdata_d = ais_stat_q;
      `ADR_AIS_IRQ_EN:  rdata_d = ais_en_q;
      `ADR_AIS_IRQ_FLG: rdata_d = ais_flg_q;
      `ADR_WAVE_BCAST:  rdata_d = wave_bcast_q;
      `ADR_WAVE_PH_ADR: rdata_d = wave_ph_adr_q;
      `ADR_WAVE_PH_DAT: rdata_d = wave_ph_dat_q;
      `ADR_WAVE_EN:     rdata_d = wave_en_q;
      `ADR_WAVE_OV_EN:  rdata_d = wave_ov_en_q;
      `ADR_WAVE_OV_FLG: rdata_d = wave_ov_flg_q;
      `ADR_CLK_REC_EN:  rdata_d = clk_rec_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  // registered outputs; a one-cycle late copy keeps every output on a flop
  // the price is one cycle of latency on each control, which the
  // channels do not notice; in return no output carries decode glitches
  // only the hardware reset clears these flops; a software reset reaches
  // the controls one cycle later through the cleared registers
  always @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      reg_rdata_o      <= 8'h00;
      reg_rvalid_o     <= 1'b0;
      analog_loop_o    <= 8'h00;
      remote_loop_o    <= 8'h00;
      all_ones_tx_o    <= 8'h00;
      digital_loop_o   <= 8'h00;
      output_disable_o <= 8'h00;
      wave_enable_o    <= 8'h00;
      clock_recovery_o <= 8'h00;
      monitor_select_o <= 4'h0;
      soft_reset_o     <= 1'b0;
    end else begin
      // read data is zero outside an answer, so no stale byte lingers
      reg_rdata_o      <= rd ? rdata_d : 8'h00;
      reg_rvalid_o     <= rd;
      analog_loop_o    <= analog_loop_q;
      remote_loop_o    <= remote_loop_q;
      all_ones_tx_o    <= all_ones_q;
      digital_loop_o   <= dig_loop_q;
      output_disable_o <= out_dis_q;
      wave_enable_o    <= wave_en_q;
      clock_recovery_o <= clk_rec_q;
      monitor_select_o <= mon_sel_q[3:0];
      soft_reset_o     <= sw_rst;
    end
  end

  // limitation: loopback, all-ones and waveform outputs carry only the
  // stored settings; which of them takes precedence is up to the channels
  // limitation: alarm mode, automatic all-ones, global control, broadcast
  // and phase registers are stored and read back, but drive no output here
  // limitation: the pulse on soft_reset_o comes on the edge of the clear, one cycle before the channel controls read zero

endmodule

// ### tb/liu_regs_sva.sv
// assertion checker for the host register bank
`timescale 1ns/1ps
module liu_regs_sva #(
  parameter [3:0] PART_NIBBLE = 4'h5,
  parameter [3:0] REVISION    = 4'h1
) (
  // clock and reset
  input wire       clk_sys_i,
  input wire       rstn_i,
  // host access
  input wire       host_mode_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       reg_rvalid_o,
  // channel controls
  input wire [7:0] analog_loop_o,
  input wire [7:0] remote_loop_o,
  input wire       soft_reset_o
);
  // accepted write; only five address bits are decoded
  wire       wr_ok = reg_wr_i && host_mode_i;
  wire [4:0] a5    = reg_addr_i[4:0];
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_read_answered: assert property (reg_rd_i && host_mode_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i && host_mode_i))
    else $error("answer without accepted read");
  a_identity_value: assert property (reg_rd_i && host_mode_i && a5 == 5'h00
    |=> reg_rdata_o == {PART_NIBBLE, REVISION}) else $error("identity wrong");
  a_analog_follows: assert property (wr_ok && a5 == 5'h01
    |-> ##2 analog_loop_o == $past(reg_wdata_i, 2)) else $error("analog loop output");
  a_remote_follows: assert property (wr_ok && a5 == 5'h02
    |-> ##2 remote_loop_o == $past(reg_wdata_i, 2)) else $error("remote loop output");
  a_soft_pulse: assert property (wr_ok && a5 == 5'h0A |=> soft_reset_o)
    else $error("soft reset pulse missing");
  a_soft_cause: assert property (soft_reset_o |-> $past(wr_ok && a5 == 5'h0A))
    else $error("soft reset pulse without write");
  a_soft_clears: assert property (wr_ok && a5 == 5'h0A ##1 !reg_wr_i
    |=> analog_loop_o == 8'h00 && remote_loop_o == 8'h00) else $error("soft reset kept");
endmodule

bind line_interface_host_register_bank liu_regs_sva #(
  .PART_NIBBLE(PART_NIBBLE),
  .REVISION(REVISION)
) u_liu_regs_sva (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .host_mode_i(host_mode_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o),
  .analog_loop_o(analog_loop_o),
  .remote_loop_o(remote_loop_o),
  .soft_reset_o(soft_reset_o)
);

// ### tb/host_model.sv
// host processor model issuing single register reads and writes
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire       clk_sys_i,
  // strobes and bus toward the bank
  output reg        reg_wr_o,
  output reg        reg_rd_o,
  output reg  [7:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o
);
  reg [7:0] exp_q[$]; // read answers still owed
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // one-cycle write; data inverted afterwards so stale values never match
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(negedge clk_sys_i);
      reg_addr_o = {3'h0, a};
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
    end
  endtask
  // one-cycle read; p notes the answer the bank owes
  task rd(input [4:0] a, input [7:0] e, input p);
    begin
      @(negedge clk_sys_i);
      reg_addr_o = {3'h0, a};
      reg_rd_o = 1'b1;
      if (p)
        exp_q.push_back(e);
      @(negedge clk_sys_i);
      reg_rd_o = 1'b0;
    end
  endtask
endmodule

// ### tb/line_interface_host_register_bank_tb_top.sv
// self-checking bench for the host register bank
`timescale 1ns/1ps
module line_interface_host_register_bank_tb_top;
  localparam [7:0]  ID = 8'h51;          // arbitrary identity given to the bank
  localparam [31:0] RO = 32'hB8280331;   // read-only and reserved addresses
  reg        clk_sys_i;
  reg        rstn_i;
  reg        host_mode_i;
  reg  [7:0] sig_abs;                   // line status stimulus
  reg  [7:0] drv_flt;
  reg  [7:0] alarm;
  reg  [7:0] ovf;
  wire       wr;
  wire       rd;
  wire [7:0] addr;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire       rvalid;
  wire [7:0] alo;
  wire [7:0] rlo;
  wire [7:0] aoo;
  wire [7:0] dlo;                       // remaining channel controls
  wire [7:0] odo;
  wire [7:0] weo;
  wire [7:0] cro;
  wire [3:0] mso;
  integer    bad_count;
  integer    samples_checked;
  integer    seed;
  integer    i;
  reg  [7:0] v;
  line_interface_host_register_bank #(.PART_NIBBLE(ID[7:4]), .REVISION(ID[3:0]))
  u_line_interface_host_register_bank (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .host_mode_i(host_mode_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .signal_absent_i(sig_abs), .driver_fault_i(drv_flt), .alarm_ind_i(alarm),
    .wave_overflow_i(ovf), .analog_loop_o(alo), .remote_loop_o(rlo), .all_ones_tx_o(aoo),
    .digital_loop_o(dlo), .output_disable_o(odo), .wave_enable_o(weo),
    .clock_recovery_o(cro), .monitor_select_o(mso), .soft_reset_o());
  host_model u_host_model (.clk_sys_i(clk_sys_i), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wdata));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // reserved bits of the masked registers read back zero
  function [7:0] msk(input [4:0] a);
    begin
      case (a)
        5'h0B:   msk = 8'h0F;
        5'h10:   msk = 8'h07;
        5'h18:   msk = 8'h7F;
        default: msk = 8'hFF;
      endcase
    end
  endfunction
  // channel output that mirrors a control register, zero where none does
  function [7:0] ctl(input [4:0] a);
    begin
      case (a)
        5'h01:   ctl = alo;
        5'h02:   ctl = rlo;
        5'h03:   ctl = aoo;
        5'h0B:   ctl = {4'h0, mso};
        5'h0C:   ctl = dlo;
        5'h12:   ctl = odo;
        5'h19:   ctl = weo;
        5'h1E:   ctl = cro;
        default: ctl = 8'h00;
      endcase
    end
  endfunction
  task conclude;
    begin
      if (bad_count == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // each answer is matched with the oldest owed value; an unowed one is wrong
  always @(negedge clk_sys_i) begin
    if (rvalid === 1'b1) begin
      if (u_host_model.exp_q.size() == 0) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: unexpected read answer", $time);
      end else
        chk(rdata, u_host_model.exp_q.pop_front());
    end
  end
  // watchdog so a stuck bank cannot hang the run
  initial begin
    #200000;
    bad_count = bad_count + 1;
    $display("mismatch at %0t: run timed out", $time);
    conclude;
  end
  initial begin
    {rstn_i, sig_abs, drv_flt, alarm, ovf} = 33'h0;
    host_mode_i = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    seed = 32'hCDC3;
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    for (i = 0; i < 32; i = i + 1)
      u_host_model.rd(i[4:0], (i == 0) ? ID : 8'h00, 1'b1);
    // every writable place keeps its value; 0Ah and 11h have tests of their own
    for (i = 1; i < 32; i = i + 1)
      if (!RO[i] && i != 10 && i != 17) begin
        v = $random(seed);
        u_host_model.wr(i[4:0], v);
        u_host_model.rd(i[4:0], v & msk(i[4:0]), 1'b1);
        if (i < 4 || i == 11 || i == 12 || i == 18 || i == 25 || i == 30)
          chk(ctl(i[4:0]), v & msk(i[4:0]));
      end
    // read-only places ignore writes of all ones
    for (i = 0; i < 32; i = i + 1)
      if (RO[i]) begin
        u_host_model.wr(i[4:0], 8'hFF);
        u_host_model.rd(i[4:0], (i == 0) ? ID : 8'h00, 1'b1);
      end
    sig_abs = $random(seed);
    drv_flt = $random(seed);
    alarm = $random(seed);
    repeat (2) @(negedge clk_sys_i);
    u_host_model.rd(5'h04, sig_abs, 1'b1);
    u_host_model.rd(5'h05, drv_flt, 1'b1);
    u_host_model.rd(5'h13, alarm, 1'b1);
    // each status edge since reset shows in its flag; a second read of 08h finds it cleared
    u_host_model.rd(5'h08, sig_abs, 1'b1);
    u_host_model.rd(5'h09, drv_flt, 1'b1);
    u_host_model.rd(5'h15, alarm, 1'b1);
    u_host_model.rd(5'h08, 8'h00, 1'b1);
    // overflow flags follow their enables and clear when read
    v = $random(seed);
    u_host_model.wr(5'h1A, v);
    u_host_model.rd(5'h1A, v, 1'b1);
    ovf = 8'hFF;
    @(negedge clk_sys_i);
    ovf = 8'h00;
    u_host_model.rd(5'h1B, v, 1'b1);
    u_host_model.rd(5'h1B, 8'h00, 1'b1);
    u_host_model.wr(5'h10, 8'hFA);
    u_host_model.rd(5'h10, 8'h02, 1'b1);
    u_host_model.wr(5'h11, 8'hFF);
    u_host_model.wr(5'h10, 8'h03);
    u_host_model.wr(5'h11, 8'h05);
    u_host_model.rd(5'h11, 8'h05, 1'b1);
    u_host_model.wr(5'h10, 8'h02);
    u_host_model.rd(5'h11, 8'h1F, 1'b1);
    // outside host mode the map is unreachable
    v = $random(seed);
    u_host_model.wr(5'h01, v);
    host_mode_i = 1'b0;
    u_host_model.wr(5'h01, ~v);
    u_host_model.rd(5'h01, v, 1'b0);
    host_mode_i = 1'b1;
    u_host_model.rd(5'h01, v, 1'b1);
    u_host_model.wr(5'h0A, 8'h5A);
    u_host_model.rd(5'h01, 8'h00, 1'b1);
    u_host_model.rd(5'h1A, 8'h00, 1'b1);
    for (i = 0; i < 20 && u_host_model.exp_q.size() != 0; i = i + 1)
      @(negedge clk_sys_i);
    if (u_host_model.exp_q.size() != 0) begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: answers missing", $time);
    end
    conclude;
  end
endmodule
